// ---- rtl/adc_fmt_pkg.sv ----
// Constants, encodings and coding helpers for the converter output stage.
// Assumes one sample per eight link clock cycles (45 degree phase steps).
package adc_fmt_pkg;

    localparam int CODE_W = 16;
    localparam int PAIR_N = 8;
    localparam int PH_W = 3;
    localparam int UA_W = 14;
    localparam int HALF_BIT = 2;

    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_DDR_SE = 2'h1;
    localparam logic [1:0] MODE_DDR_DIFF = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;

    localparam logic [PH_W-1:0] PH_FIRST = 3'h0;
    localparam logic [PH_W-1:0] PH_STEP = 3'h1;
    localparam logic [PH_W-1:0] PH_HALF = 3'h4;
    localparam logic [PH_W-1:0] PH_LAST = 3'h7;

    localparam logic [2:0] CUR_3P5 = 3'h0;
    localparam logic [2:0] CUR_4P0 = 3'h1;
    localparam logic [2:0] CUR_4P5 = 3'h2;
    localparam logic [2:0] CUR_3P0 = 3'h4;
    localparam logic [2:0] CUR_2P5 = 3'h5;
    localparam logic [2:0] CUR_2P1 = 3'h6;
    localparam logic [2:0] CUR_1P75 = 3'h7;

    localparam logic [CODE_W-1:0] CODE_MAX = 16'hFFFF;
    localparam logic [CODE_W-1:0] CODE_MIN = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_MID = 16'h8000;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] phase;
        logic       invert;
        logic       twos;
        logic       randomize;
        logic [2:0] cur;
        logic       term;
    } cfg_type;

    localparam int CFG_W = $bits(cfg_type);

    // Driver current in microamps per current code
    function automatic logic [UA_W-1:0] cur_ua(input logic [2:0] code);
        case (code)
            CUR_4P0: cur_ua = 14'h0FA0;
            CUR_4P5: cur_ua = 14'h1194;
            CUR_3P0: cur_ua = 14'h0BB8;
            CUR_2P5: cur_ua = 14'h09C4;
            CUR_2P1: cur_ua = 14'h0834;
            CUR_1P75: cur_ua = 14'h06D6;
            default: cur_ua = 14'h0DAC;
        endcase
    endfunction : cur_ua

    // Saturation, then coding, then randomizer
    function automatic logic [CODE_W-1:0] coded(
        input logic [CODE_W-1:0] raw,
        input logic              above,
        input logic              below,
        input logic              twos,
        input logic              randomize
    );
        logic [CODE_W-1:0] v;
        v = raw;
        if (above) begin
            v = CODE_MAX;
        end else if (below) begin
            v = CODE_MIN;
        end
        if (twos) begin
            v = v ^ CODE_MID;
        end
        if (randomize) begin
            v = v ^ {{(CODE_W-1){v[0]}}, 1'b0};
        end
        coded = v;
    endfunction : coded

endpackage : adc_fmt_pkg

// ---- rtl/bit_sync.sv ----
// Two flip-flop synchroniser for quasi-static levels.
// Assumes the source is a flop or a pin; no reset, so it may carry reset.
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] hold;
    } sync_state_type;

    sync_state_type s_r;
    sync_state_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = i_async;
        s_nxt.hold = s_r.meta;
    end

    always_ff @(posedge i_clk) begin
        s_r <= s_nxt;
    end

    assign o_sync = s_r.hold;

endmodule : bit_sync

// ---- rtl/adc_output_formatter.sv ----
// Output formatting and transmit stage of a dual 16-bit converter.
// Assumes samples on the link clock, eight link cycles per sample.
`timescale 1ns/1ps
module adc_output_formatter
    import adc_fmt_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_sys_rst,
    input  wire logic              i_clk_link,
    input  wire logic              i_config_path_select,
    input  wire logic              i_strap_mode_pin,
    input  wire logic [1:0]        i_mode_sel,
    input  wire logic [1:0]        i_phase_sel,
    input  wire logic              i_clk_invert,
    input  wire logic              i_twos_comp,
    input  wire logic              i_randomize,
    input  wire logic [2:0]        i_current_sel,
    input  wire logic              i_term_enable,
    input  wire logic [CODE_W-1:0] i_ch1_code,
    input  wire logic [CODE_W-1:0] i_ch2_code,
    input  wire logic              i_ch1_above,
    input  wire logic              i_ch1_below,
    input  wire logic              i_ch2_above,
    input  wire logic              i_ch2_below,
    output logic                   o_sample_take,
    output logic      [CODE_W-1:0] o_ch1_bit_line,
    output logic      [CODE_W-1:0] o_ch2_bit_line,
    output logic                   o_range_flag_ch1,
    output logic                   o_range_flag_ch2,
    output logic                   o_range_flag_merged,
    output logic                   o_strobe_p,
    output logic                   o_strobe_n,
    output logic                   o_diff_mode,
    output logic                   o_term_on,
    output logic      [UA_W-1:0]   o_drive_ua,
    output logic      [1:0]        o_mode_active
);

    typedef struct packed {
        cfg_type cfg;
    } sys_state_type;

    typedef struct packed {
        logic [PH_W-1:0]   ph;
        cfg_type           cfg_a;
        cfg_type           cfg;
        logic [CODE_W-1:0] stage1;
        logic [CODE_W-1:0] stage2;
        logic              of1;
        logic              of2;
        logic [CODE_W-1:0] line1;
        logic [CODE_W-1:0] line2;
        logic              flag1;
        logic              flag2;
        logic              merged;
        logic              strobe_p;
        logic              strobe_n;
        logic              diff;
        logic              term;
        logic [UA_W-1:0]   ua;
    } link_state_type;

    sys_state_type     s_r;
    sys_state_type     s_nxt;
    link_state_type    l_r;
    link_state_type    l_nxt;
    logic [1:0]        pins_sync;
    cfg_type           cfg_sync;
    logic              rst_link;
    logic [PH_W-1:0]   ph_nxt;
    logic              take;
    cfg_type           cfg_nxt;
    logic [CODE_W-1:0] st1_nxt;
    logic [CODE_W-1:0] st2_nxt;
    logic              of1_nxt;
    logic              of2_nxt;
    logic [PH_W-1:0]   shifted;
    logic [PAIR_N-1:0] ddr1;
    logic [PAIR_N-1:0] ddr2;

    bit_sync #(.W(2)) u_pin_sync (
        .i_clk   (i_clk_sys),
        .i_async ({i_config_path_select, i_strap_mode_pin}),
        .o_sync  (pins_sync)
    );

    bit_sync #(.W(CFG_W)) u_cfg_sync (
        .i_clk   (i_clk_link),
        .i_async (s_r.cfg),
        .o_sync  (cfg_sync)
    );

    bit_sync #(.W(1)) u_rst_sync (
        .i_clk   (i_clk_link),
        .i_async (i_sys_rst),
        .o_sync  (rst_link)
    );

    // Effective configuration from strap or serial path
    always_comb begin
        s_nxt = s_r;
        if (i_sys_rst) begin
            s_nxt.cfg = '0;
        end else begin
            s_nxt.cfg.phase = i_phase_sel;
            s_nxt.cfg.invert = i_clk_invert;
            s_nxt.cfg.twos = i_twos_comp;
            s_nxt.cfg.randomize = i_randomize;
            if (pins_sync[1]) begin
                s_nxt.cfg.mode = pins_sync[0] ? MODE_DDR_DIFF : MODE_FULL;
                s_nxt.cfg.cur = CUR_3P5;
                s_nxt.cfg.term = 1'b0;
            end else begin
                s_nxt.cfg.mode = (i_mode_sel == MODE_RSVD) ? MODE_FULL
                                                           : i_mode_sel;
                s_nxt.cfg.cur = i_current_sel;
                s_nxt.cfg.term = i_term_enable;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        s_r <= s_nxt;
    end

    assign o_mode_active = s_r.cfg.mode;

    // Slot counter, sample capture and coding
    assign ph_nxt = l_r.ph + PH_STEP;
    assign take = (l_r.ph == PH_LAST);
    assign o_sample_take = take & ~rst_link;
    assign cfg_nxt = (take && cfg_sync == l_r.cfg_a) ? l_r.cfg_a : l_r.cfg;
    assign st1_nxt = take ? coded(i_ch1_code, i_ch1_above, i_ch1_below,
                                  cfg_nxt.twos, cfg_nxt.randomize)
                          : l_r.stage1;
    assign st2_nxt = take ? coded(i_ch2_code, i_ch2_above, i_ch2_below,
                                  cfg_nxt.twos, cfg_nxt.randomize)
                          : l_r.stage2;
    assign of1_nxt = take ? (i_ch1_above | i_ch1_below) : l_r.of1;
    assign of2_nxt = take ? (i_ch2_above | i_ch2_below) : l_r.of2;
    assign shifted = ph_nxt - {1'b0, cfg_nxt.phase};

    genvar k;
    generate
        for (k = 0; k < PAIR_N; k++) begin : g_pair
            assign ddr1[k] = st1_nxt[2*k + ph_nxt[HALF_BIT]];
            assign ddr2[k] = st2_nxt[2*k + ph_nxt[HALF_BIT]];
        end
    endgenerate

    always_comb begin
        l_nxt = l_r;
        if (rst_link) begin
            l_nxt = '0;
        end else begin
            l_nxt.ph = ph_nxt;
            l_nxt.cfg_a = cfg_sync;
            l_nxt.cfg = cfg_nxt;
            l_nxt.stage1 = st1_nxt;
            l_nxt.stage2 = st2_nxt;
            l_nxt.of1 = of1_nxt;
            l_nxt.of2 = of2_nxt;
            l_nxt.strobe_p = shifted[HALF_BIT] ^ cfg_nxt.invert;
            l_nxt.strobe_n = ~(shifted[HALF_BIT] ^ cfg_nxt.invert);
            case (cfg_nxt.mode)
                MODE_FULL: begin
                    l_nxt.line1 = st1_nxt;
                    l_nxt.line2 = st2_nxt;
                    l_nxt.flag1 = of1_nxt;
                    l_nxt.flag2 = of2_nxt;
                    l_nxt.merged = 1'b0;
                end
                default: begin
                    l_nxt.line1 = {{(CODE_W-PAIR_N){1'b0}}, ddr1};
                    l_nxt.line2 = {{(CODE_W-PAIR_N){1'b0}}, ddr2};
                    l_nxt.flag1 = 1'b0;
                    l_nxt.flag2 = 1'b0;
                    l_nxt.merged = ph_nxt[HALF_BIT] ? of2_nxt : of1_nxt;
                end
            endcase
            l_nxt.diff = (cfg_nxt.mode == MODE_DDR_DIFF);
            l_nxt.term = l_nxt.diff & cfg_nxt.term;
            if (!l_nxt.diff) begin
                l_nxt.ua = '0;
            end else if (cfg_nxt.term) begin
                l_nxt.ua = cur_ua(cfg_nxt.cur) << 1;
            end else begin
                l_nxt.ua = cur_ua(cfg_nxt.cur);
            end
        end
    end

    always_ff @(posedge i_clk_link) begin
        l_r <= l_nxt;
    end

    assign o_ch1_bit_line = l_r.line1;
    assign o_ch2_bit_line = l_r.line2;
    assign o_range_flag_ch1 = l_r.flag1;
    assign o_range_flag_ch2 = l_r.flag2;
    assign o_range_flag_merged = l_r.merged;
    assign o_strobe_p = l_r.strobe_p;
    assign o_strobe_n = l_r.strobe_n;
    assign o_diff_mode = l_r.diff;
    assign o_term_on = l_r.term;
    assign o_drive_ua = l_r.ua;

    // Checks
    logic ddr_r;
    logic plain_clk;
    assign ddr_r = (l_r.cfg.mode != MODE_FULL);
    assign plain_clk = (l_r.cfg.phase == 2'h0) && !l_r.cfg.invert;

    strap_mode_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        pins_sync[1] |=> (s_r.cfg.mode == ($past(pins_sync[0]) ?
            MODE_DDR_DIFF : MODE_FULL)) && s_r.cfg.cur == CUR_3P5
            && !s_r.cfg.term)
        else $error("strap mode wrong");

    serial_mode_a: assert property (
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (!pins_sync[1] && i_mode_sel == MODE_DDR_SE)
        |=> s_r.cfg.mode == MODE_DDR_SE)
        else $error("serial mode not taken");

    sequence merged_halves_s;
        o_range_flag_merged == l_r.of1 ##4 o_range_flag_merged == l_r.of2;
    endsequence

    merged_flag_a: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        (ddr_r && l_r.ph == PH_FIRST && $stable(l_r.cfg))
        |-> merged_halves_s)
        else $error("merged flag order wrong");

    ddr_pairing_a: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        ddr_r |-> o_ch1_bit_line[0] == l_r.stage1[l_r.ph[HALF_BIT]]
            && o_ch1_bit_line[CODE_W-1:PAIR_N] == '0)
        else $error("pair slot wrong");

    full_edge_a: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        (!ddr_r && plain_clk && $stable(l_r.cfg) && $changed(o_ch1_bit_line))
        |-> $fell(o_strobe_p))
        else $error("full rate change off falling edge");

    ddr_edge_a: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        (ddr_r && plain_clk && $stable(l_r.cfg) && $changed(o_ch1_bit_line))
        |-> $changed(o_strobe_p))
        else $error("ddr change off strobe edge");

    phase_shift_a: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        ($rose(o_strobe_p) && !l_r.cfg.invert && $stable(l_r.cfg))
        |-> l_r.ph == PH_HALF + {1'b0, l_r.cfg.phase})
        else $error("strobe phase wrong");

    invert_clk_a: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        ($rose(o_strobe_p) && l_r.cfg.invert && $stable(l_r.cfg))
        |-> l_r.ph == PH_FIRST + {1'b0, l_r.cfg.phase}
            && o_strobe_n == !o_strobe_p)
        else $error("inverted strobe wrong");

    range_latency_a: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        (take && cfg_nxt.mode == MODE_FULL)
        |=> o_range_flag_ch1 == $past(i_ch1_above | i_ch1_below))
        else $error("range flag latency wrong");

    saturate_top_a: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        (take && cfg_nxt.mode == MODE_FULL && !cfg_nxt.twos
            && !cfg_nxt.randomize && i_ch1_above)
        |=> o_ch1_bit_line == CODE_MAX)
        else $error("no saturation");

    twos_mid_a: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        (take && cfg_nxt.mode == MODE_FULL && cfg_nxt.twos
            && !cfg_nxt.randomize && i_ch1_code == CODE_MID
            && !i_ch1_above && !i_ch1_below)
        |=> o_ch1_bit_line == CODE_MIN)
        else $error("midscale two's complement wrong");

    randomizer_a: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        (take && cfg_nxt.mode == MODE_FULL && cfg_nxt.randomize
            && !cfg_nxt.twos && !i_ch1_above && !i_ch1_below)
        |=> (o_ch1_bit_line ^ {{(CODE_W-1){o_ch1_bit_line[0]}}, 1'b0})
            == $past(i_ch1_code))
        else $error("randomizer not reversible");

    drive_current_a: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        (o_diff_mode && $stable(l_r.cfg)) |-> o_drive_ua ==
            (l_r.cfg.term ? cur_ua(l_r.cfg.cur) << 1
                          : cur_ua(l_r.cfg.cur)))
        else $error("driver current wrong");

endmodule : adc_output_formatter

// ---- verification/strobe_receiver.sv ----
// Receiver model latching converter data with the forwarded strobe.
// Assumes full rate unshifted and DDR with a 45 degree strobe shift.
`timescale 1ns/1ps
module strobe_receiver (
    input  wire logic        i_ddr,
    input  wire logic        i_derand,
    input  wire logic        i_strobe,
    input  wire logic [15:0] i_line1,
    input  wire logic [15:0] i_line2,
    input  wire logic        i_flag1,
    input  wire logic        i_flag2,
    input  wire logic        i_flag_m,
    output logic      [15:0] o_word1,
    output logic      [15:0] o_word2,
    output logic             o_of1,
    output logic             o_of2,
    output logic      [7:0]  o_count
);
    logic [7:0] even1;
    logic [7:0] even2;
    logic       of_even;

    function automatic logic [15:0] undo(input logic [15:0] w);
        undo = i_derand ? w ^ {{15{w[0]}}, 1'b0} : w;
    endfunction : undo

    function automatic logic [15:0] weave(input logic [7:0] e,
                                          input logic [7:0] o);
        for (int k = 0; k < 8; k++) begin
            weave[2*k]   = e[k];
            weave[2*k+1] = o[k];
        end
    endfunction : weave

    initial o_count = 8'h00;

    always @(negedge i_strobe) begin
        even1   <= i_line1[7:0];
        even2   <= i_line2[7:0];
        of_even <= i_flag_m;
    end

    always @(posedge i_strobe) begin
        o_word1 <= undo(i_ddr ? weave(even1, i_line1[7:0]) : i_line1);
        o_word2 <= undo(i_ddr ? weave(even2, i_line2[7:0]) : i_line2);
        o_of1   <= i_ddr ? of_even : i_flag1;
        o_of2   <= i_ddr ? i_flag_m : i_flag2;
        o_count <= o_count + 8'h01;
    end
endmodule : strobe_receiver

// ---- verification/adc_output_formatter_tb_top.sv ----
// Self-checking bench for the converter output stage.
// Assumes the package, the design and the receiver model compiled first.
`timescale 1ns/1ps
module adc_output_formatter_tb_top
    import adc_fmt_pkg::*;
;
    logic        i_clk_sys, i_sys_rst, i_clk_link, i_config_path_select;
    logic        i_strap_mode_pin, i_clk_invert, i_twos_comp, i_randomize;
    logic        i_term_enable, i_ch1_above, i_ch1_below, i_ch2_above;
    logic        i_ch2_below, o_sample_take, o_range_flag_ch1, o_strobe_p;
    logic        o_range_flag_ch2, o_range_flag_merged, o_strobe_n;
    logic        o_diff_mode, o_term_on, rx_ddr, rx_derand, rx_of1, rx_of2;
    logic [1:0]  i_mode_sel, i_phase_sel, o_mode_active;
    logic [2:0]  i_current_sel;
    logic [15:0] i_ch1_code, i_ch2_code, o_ch1_bit_line, o_ch2_bit_line;
    logic [15:0] rx_word1, rx_word2;
    logic [13:0] o_drive_ua;
    logic [7:0]  rx_count;
    int          num_errors, checks_done;
    logic [15:0] ua [8] = '{16'h0DAC, 16'h0FA0, 16'h1194, 16'h0DAC,
                            16'h0BB8, 16'h09C4, 16'h0834, 16'h06D6};

    adc_output_formatter adc_output_formatter_i (
        .i_clk_sys, .i_sys_rst, .i_clk_link, .i_config_path_select,
        .i_strap_mode_pin, .i_mode_sel, .i_phase_sel, .i_clk_invert,
        .i_twos_comp, .i_randomize, .i_current_sel, .i_term_enable,
        .i_ch1_code, .i_ch2_code, .i_ch1_above, .i_ch1_below,
        .i_ch2_above, .i_ch2_below, .o_sample_take, .o_ch1_bit_line,
        .o_ch2_bit_line, .o_range_flag_ch1, .o_range_flag_ch2,
        .o_range_flag_merged, .o_strobe_p, .o_strobe_n, .o_diff_mode,
        .o_term_on, .o_drive_ua, .o_mode_active);

    strobe_receiver strobe_receiver_i (
        .i_ddr(rx_ddr), .i_derand(rx_derand), .i_strobe(o_strobe_p),
        .i_line1(o_ch1_bit_line), .i_line2(o_ch2_bit_line),
        .i_flag1(o_range_flag_ch1), .i_flag2(o_range_flag_ch2),
        .i_flag_m(o_range_flag_merged), .o_word1(rx_word1),
        .o_word2(rx_word2), .o_of1(rx_of1), .o_of2(rx_of2),
        .o_count(rx_count));

    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        i_clk_link = 1'b0;
        #7.3;
        forever #24 i_clk_link = ~i_clk_link;
    end

    // Expected word: saturate, code, randomize
    function automatic logic [15:0] enc(input logic [15:0] r,
        input logic a, input logic b, input logic t, input logic z);
        logic [15:0] v;
        v = a ? 16'hFFFF : (b ? 16'h0000 : r);
        if (t) v[15] = ~v[15];
        if (z) v[15:1] = v[15:1] ^ {15{v[0]}};
        enc = v;
    endfunction : enc

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_up();
        num_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        wrap_up();
    endtask : give_up

    task automatic settle();
        repeat (24) @(negedge i_clk_link);
        @(negedge i_clk_sys);
    endtask : settle

    task automatic sample(input logic [15:0] c1, input logic [15:0] c2,
                          input logic [3:0] f);
        logic [7:0] n0;
        logic       z;
        {i_ch1_above, i_ch1_below, i_ch2_above, i_ch2_below} = f;
        i_ch1_code = c1;
        i_ch2_code = c2;
        n0 = rx_count;
        for (int k = 0; k < 80 && rx_count != n0 + 8'h02; k++) begin
            @(negedge i_clk_link);
        end
        if (rx_count !== n0 + 8'h02) give_up();
        z = i_randomize & ~rx_derand;
        chk(rx_word1, enc(c1, f[3], f[2], i_twos_comp, z));
        chk(rx_word2, enc(c2, f[1], f[0], i_twos_comp, z));
        chk(16'({rx_of1, rx_of2}), 16'({|f[3:2], |f[1:0]}));
        chk(rx_ddr ? {o_ch1_bit_line[15:8], o_ch2_bit_line[15:8]}
                     | 16'({o_range_flag_ch1, o_range_flag_ch2})
                   : 16'(o_range_flag_merged), 16'h0000);
        @(negedge i_clk_sys);
    endtask : sample

    task automatic vecs();
        sample(16'h8000, 16'h7FFF, 4'h0);
        sample(16'h0123, 16'hC3A5, 4'h8);
        sample(16'h5A5B, 16'hFEDC, 4'h1);
    endtask : vecs

    task automatic t_coding();
        for (int m = 0; m < 5; m++) begin
            {i_twos_comp, i_randomize} = 2'(m == 4 ? 3 : m);
            rx_derand = (m == 4);
            settle();
            chk(16'({o_mode_active, o_diff_mode}), 16'h0000);
            chk(16'(o_drive_ua), 16'h0000);
            vecs();
        end
        $display("test coding done");
    endtask : t_coding

    task automatic t_phase();
        logic e;
        int   k;
        for (int m = 0; m < 8; m++) begin
            {i_clk_invert, i_phase_sel} = 3'(m);
            settle();
            for (k = 0; k < 20 && o_sample_take !== 1'b1; k++) begin
                @(negedge i_clk_link);
            end
            if (k == 20) give_up();
            for (int s = 7; s < 15; s++) begin
                e = (3'(s - m % 4) >= 3'h4) ^ (m >= 4);
                chk(16'({o_strobe_p, o_strobe_n}), 16'({e, ~e}));
                @(negedge i_clk_link);
            end
            @(negedge i_clk_sys);
        end
        $display("test phase done");
    endtask : t_phase

    task automatic t_ddr();
        for (int m = 1; m < 3; m++) begin
            i_mode_sel = 2'(m);
            // Stabilizer taken as on for shifts
            {i_clk_invert, i_phase_sel} = 3'h1;
            rx_ddr = 1'b1;
            settle();
            chk(16'({o_mode_active, o_diff_mode}), 16'(m * 3 - 1));
            vecs();
        end
        $display("test ddr done");
    endtask : t_ddr

    task automatic t_current();
        for (int m = 0; m < 16; m++) begin
            {i_term_enable, i_current_sel} = 4'(m);
            settle();
            chk(16'(o_drive_ua), ua[m % 8] << (m / 8));
            chk(16'(o_term_on), 16'(m / 8));
        end
        $display("test current done");
    endtask : t_current

    task automatic t_strap();
        i_config_path_select = 1'b1;
        i_mode_sel = MODE_DDR_SE;
        for (int p = 0; p < 2; p++) begin
            i_strap_mode_pin = p[0];
            settle();
            chk(16'(o_mode_active), 16'(p * 2));
            chk(16'({o_diff_mode, o_term_on}), 16'(p * 2));
            chk(16'(o_drive_ua), 16'(p * 3500));
        end
        i_config_path_select = 1'b0;
        i_mode_sel = MODE_RSVD;
        settle();
        chk(16'(o_mode_active), 16'(MODE_FULL));
        $display("test strap done");
    endtask : t_strap

    initial begin
        {i_config_path_select, i_strap_mode_pin, i_clk_invert} = '0;
        {i_twos_comp, i_randomize, i_term_enable, rx_ddr, rx_derand} = '0;
        {i_ch1_above, i_ch1_below, i_ch2_above, i_ch2_below} = '0;
        {i_mode_sel, i_phase_sel, i_current_sel} = '0;
        {i_ch1_code, i_ch2_code} = '0;
        i_sys_rst = 1'b1;
        num_errors = 0;
        checks_done = 0;
        repeat (12) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        repeat (2) @(negedge i_clk_link);
        chk(16'({o_strobe_p, o_strobe_n, o_mode_active}), 16'h0000);
        @(negedge i_clk_sys);
        t_coding();
        t_phase();
        t_ddr();
        t_current();
        t_strap();
        wrap_up();
    end
endmodule : adc_output_formatter_tb_top
